/* include/mode_ctrl_pkg.sv */
// Constants and types shared by the operating-mode controller.
// Assumes a 20 MHz system clock and a synchronous active-high reset.
`default_nettype none

package mode_ctrl_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned STARTUP_BLINK_MS = 3000;
	localparam int unsigned WATCHDOG_MS     = 100;
	localparam int unsigned CYCLE_LIMIT_MIN_MS = 1;
	localparam int unsigned BLINK_HALF_MS   = 250;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned STARTUP_BLINK_CYC = STARTUP_BLINK_MS * CYC_PER_MS;
	localparam int unsigned WATCHDOG_CYC    = WATCHDOG_MS * CYC_PER_MS;
	localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * CYC_PER_MS;
	localparam int unsigned CYCLE_LIMIT_MIN_CYC = CYCLE_LIMIT_MIN_MS * CYC_PER_MS;
	localparam int unsigned TIMER_W         = 27;

	// ------------------------------------------------------------
	// Modes and cycle phases
	// ------------------------------------------------------------
	localparam int unsigned MAX_BREAKPOINTS = 3;
	localparam int unsigned MAX_STEP_BREAKPOINTS = 2;
	localparam int unsigned BP_COUNT_W      = 2;

	typedef enum logic [1:0] {
		MODE_STOP    = 2'h0,
		MODE_STARTUP = 2'h1,
		MODE_RUN     = 2'h2,
		MODE_HOLD    = 2'h3
	} op_mode_t;

	typedef enum logic [2:0] {
		PH_CLEAR_IN,
		PH_STARTUP,
		PH_CLEAR_OUT,
		PH_READ_IN,
		PH_EXEC,
		PH_WRITE_OUT
	} phase_t;

	// ------------------------------------------------------------
	// Analog safe values
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		AOUT_VOLT,
		AOUT_CUR_0_20,
		AOUT_CUR_4_20,
		AOUT_SUBST
	} aout_range_t;

	localparam int unsigned AOUT_W       = 16;
	localparam logic [15:0] AOUT_ZERO    = 16'h0000;
	localparam logic [15:0] AOUT_4MA     = 16'h1999;

endpackage : mode_ctrl_pkg

`default_nettype wire

/* hdl/down_counter.sv */
// Loadable down counter with a terminal-count flag.
// Assumes the synchronous reset and single clock of the controller.
`default_nettype none

module down_counter #(
	parameter int unsigned WIDTH = 27
) (
	input  wire logic             sys_clk, // System clock
	input  wire logic             rst,     // Synchronous reset
	input  wire logic             load,    // Load count value
	input  wire logic [WIDTH-1:0] value,   // Value loaded
	input  wire logic             run,     // Count enable
	output logic                  zero     // Count has reached zero
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;

	assign count_next = load ? value :
		(run && count_reg != '0) ? count_reg - 1'b1 : count_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	assign zero = (count_reg == '0);

endmodule : down_counter

`default_nettype wire

/* hdl/plc_mode_ctrl.sv */
// Operating-mode controller: stop, start-up, run and halt sequencing.
// Assumes program execution is done elsewhere and reported by strobes.
`default_nettype none

// Contract
// - exactly one of four modes held
// - stop keeps counters, timers, flags, images
// - stop: no execution, outputs locked, lamps
// - start-up: outputs locked, stop lamp off, unwatched
// - run lamp blinks at least three seconds
// - start-up completion enters run
// - run: lock released, run lamp on
// - run: timers active, image refreshed per cycle
// - at most three breakpoints
// - breakpoint halts; step or resume allowed
// - halt: run lamp blinks, stop lamp lit
// - halt: all execution stopped
// - halt: timers frozen, clock and links kept
// - halt: output lock asserted
// - more than two breakpoints refuse stepping
// - 100 ms watchdog forces defined stop
// - cycle limit at least 1 ms, forces stop
// - run to stop: lock, analog safe values
// - clear inputs, start-up, unlock, clear outputs
// - cycle: read inputs, execute, write outputs
// - overall reset erases user memory only
module plc_mode_ctrl
	import mode_ctrl_pkg::*;
(
	input  wire logic                 sys_clk,        // System clock
	input  wire logic                 rst,            // Sync reset
	input  wire logic                 run_request,    // Request run
	input  wire logic                 stop_request,   // Request stop
	input  wire logic                 startup_done,   // Start-up ended
	input  wire logic                 startup_error,  // Start-up failed
	input  wire logic                 phase_done,     // Phase ended
	input  wire logic                 bp_reached,     // Breakpoint hit
	input  wire logic [1:0]           bp_count,       // Breakpoints set
	input  wire logic                 bp_active,      // Breakpoints on
	input  wire logic                 step_request,   // Execute next
	input  wire logic                 resume_request, // Resume
	input  wire logic                 wdog_kick,      // Watchdog retrigger
	input  wire logic [TIMER_W-1:0]   cycle_limit,    // Cycle limit cycles
	input  wire logic                 overall_reset,  // Erase request
	input  wire aout_range_t          aout_range,     // Analog range
	input  wire logic [AOUT_W-1:0]    aout_subst,     // Substitute value
	input  wire logic [AOUT_W-1:0]    aout_prog,      // Program value
	output op_mode_t                  mode,           // Current mode
	output logic                      output_lock,    // Outputs inhibited
	output logic                      run_lamp,       // Run lamp
	output logic                      stop_lamp,      // Stop lamp
	output logic [AOUT_W-1:0]         aout_value,     // Analog output
	output logic                      exec_enable,    // Execution allowed
	output logic                      timers_enable,  // Program timers run
	output logic                      clear_input_image,  // Clear strobe
	output logic                      clear_output_image, // Clear strobe
	output logic                      read_input_image,   // Read level
	output logic                      run_cyclic_routine, // Execute level
	output logic                      write_output_image, // Write level
	output logic                      run_startup_routine, // Start-up level
	output logic                      step_granted,   // One statement
	output logic                      step_refused,   // Step refused
	output logic                      wdog_fault,     // Watchdog expired
	output logic                      cycle_fault,    // Cycle overrun
	output logic                      erase_user_mem  // Erase strobe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	op_mode_t mode_reg;
	op_mode_t mode_next;
	phase_t   phase_reg;
	phase_t   phase_next;
	logic     blink_reg;
	logic     blink_hold_reg;
	logic     blink_hold_next;
	logic     lamp_run_reg;
	logic     lamp_stop_reg;
	logic     lock_reg;
	logic [AOUT_W-1:0] aout_reg;
	logic [AOUT_W-1:0] aout_next;
	logic     step_grant_reg;
	logic     step_refuse_reg;
	logic     wdog_fault_reg;
	logic     cycle_fault_reg;
	logic     erase_reg;
	logic     first_cycle_reg;

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	logic startup_min_zero;
	logic wdog_zero;
	logic cycle_zero;
	logic blink_zero;
	logic entering_startup;
	logic wdog_active;
	logic cycle_start;
	logic [TIMER_W-1:0] limit_eff;

	assign entering_startup = (mode_reg != MODE_STARTUP) &&
		(mode_next == MODE_STARTUP);
	// Start-up is not watched; halt suspends and rearms supervision
	assign wdog_active = (mode_reg == MODE_RUN);
	assign cycle_start = (mode_reg == MODE_RUN) &&
		(phase_reg == PH_WRITE_OUT) && phase_done;
	assign limit_eff = (cycle_limit < TIMER_W'(CYCLE_LIMIT_MIN_CYC)) ?
		TIMER_W'(CYCLE_LIMIT_MIN_CYC) : cycle_limit;

	down_counter #(.WIDTH(TIMER_W)) u_startup_min (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (entering_startup),
		.value   (TIMER_W'(STARTUP_BLINK_CYC)),
		.run     (1'b1),
		.zero    (startup_min_zero)
	);

	down_counter #(.WIDTH(TIMER_W)) u_wdog (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (!wdog_active || wdog_kick),
		.value   (TIMER_W'(WATCHDOG_CYC)),
		.run     (wdog_active),
		.zero    (wdog_zero)
	);

	down_counter #(.WIDTH(TIMER_W)) u_cycle (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (!wdog_active || cycle_start),
		.value   (limit_eff),
		.run     (wdog_active),
		.zero    (cycle_zero)
	);

	down_counter #(.WIDTH(TIMER_W)) u_blink (
		.sys_clk (sys_clk),
		.rst     (rst),
		.load    (blink_zero),
		.value   (TIMER_W'(BLINK_HALF_CYC)),
		.run     (1'b1),
		.zero    (blink_zero)
	);

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	logic wdog_expire;
	logic cycle_expire;
	logic fault_stop;
	logic step_ok;

	assign wdog_expire  = wdog_active && wdog_zero;
	assign cycle_expire = wdog_active && cycle_zero;
	assign fault_stop   = wdog_expire || cycle_expire;
	// Up to three breakpoints; stepping only with two or fewer
	assign step_ok = (bp_count <= BP_COUNT_W'(MAX_STEP_BREAKPOINTS));

	always_comb begin
		mode_next = mode_reg;
		unique case (mode_reg)
			MODE_STOP: begin
				if (run_request) begin
					mode_next = MODE_STARTUP;
				end
			end
			MODE_STARTUP: begin
				if (stop_request || startup_error) begin
					mode_next = MODE_STOP;
				end else if (phase_reg == PH_STARTUP && startup_done) begin
					mode_next = MODE_RUN;
				end
			end
			MODE_RUN: begin
				if (stop_request || fault_stop) begin
					mode_next = MODE_STOP;
				end else if (bp_active && bp_reached &&
					phase_reg == PH_EXEC) begin
					mode_next = MODE_HOLD;
				end
			end
			MODE_HOLD: begin
				if (stop_request) begin
					mode_next = MODE_STOP;
				end else if (resume_request ||
					(step_request && step_ok)) begin
					mode_next = MODE_RUN;
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Cycle phases
	// ------------------------------------------------------------
	always_comb begin
		phase_next = phase_reg;
		if (mode_next == MODE_STOP) begin
			phase_next = PH_CLEAR_IN;
		end else if (entering_startup) begin
			phase_next = PH_CLEAR_IN;
		end else if (mode_reg == MODE_HOLD) begin
			phase_next = phase_reg;
		end else begin
			unique case (phase_reg)
				PH_CLEAR_IN:  phase_next = PH_STARTUP;
				PH_STARTUP: begin
					if (mode_next == MODE_RUN) begin
						phase_next = PH_CLEAR_OUT;
					end
				end
				PH_CLEAR_OUT: phase_next = PH_READ_IN;
				PH_READ_IN: begin
					if (phase_done) begin
						phase_next = PH_EXEC;
					end
				end
				PH_EXEC: begin
					if (phase_done && mode_next == MODE_RUN) begin
						phase_next = PH_WRITE_OUT;
					end
				end
				PH_WRITE_OUT: begin
					if (phase_done) begin
						phase_next = PH_READ_IN;
					end
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Lamps, lock and analog safe value
	// ------------------------------------------------------------
	logic lamp_run_next;
	logic lamp_stop_next;
	logic lock_next;

	// Start-up blink survives an early exit until the minimum expires
	assign blink_hold_next = entering_startup ? 1'b1 :
		(startup_min_zero ? 1'b0 : blink_hold_reg);

	always_comb begin
		lamp_run_next  = 1'b0;
		lamp_stop_next = 1'b1;
		lock_next      = 1'b1;
		unique case (mode_next)
			MODE_STOP: begin
				lamp_run_next  = blink_hold_next && blink_reg;
				lamp_stop_next = 1'b1;
				lock_next      = 1'b1;
			end
			MODE_STARTUP: begin
				lamp_run_next  = blink_reg;
				lamp_stop_next = 1'b0;
				lock_next      = 1'b1;
			end
			MODE_RUN: begin
				lamp_run_next  = blink_hold_next ? blink_reg : 1'b1;
				lamp_stop_next = 1'b0;
				lock_next      = 1'b0;
			end
			MODE_HOLD: begin
				lamp_run_next  = blink_reg;
				lamp_stop_next = 1'b1;
				lock_next      = 1'b1;
			end
		endcase
	end

	always_comb begin
		aout_next = aout_prog;
		if (lock_next) begin
			unique case (aout_range)
				AOUT_VOLT:     aout_next = AOUT_ZERO;
				AOUT_CUR_0_20: aout_next = AOUT_ZERO;
				AOUT_CUR_4_20: aout_next = AOUT_4MA;
				AOUT_SUBST:    aout_next = aout_subst;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_reg       <= MODE_STOP;
			phase_reg      <= PH_CLEAR_IN;
			blink_reg      <= 1'b0;
			blink_hold_reg <= 1'b0;
			lamp_run_reg   <= 1'b0;
			lamp_stop_reg  <= 1'b1;
			lock_reg       <= 1'b1;
			aout_reg       <= AOUT_ZERO;
		end else begin
			mode_reg       <= mode_next;
			phase_reg      <= phase_next;
			blink_reg      <= blink_zero ? ~blink_reg : blink_reg;
			blink_hold_reg <= blink_hold_next;
			lamp_run_reg   <= lamp_run_next;
			lamp_stop_reg  <= lamp_stop_next;
			lock_reg       <= lock_next;
			aout_reg       <= aout_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			step_grant_reg  <= 1'b0;
			step_refuse_reg <= 1'b0;
			wdog_fault_reg  <= 1'b0;
			cycle_fault_reg <= 1'b0;
			erase_reg       <= 1'b0;
			first_cycle_reg <= 1'b0;
		end else begin
			step_grant_reg  <= (mode_reg == MODE_HOLD) && !stop_request &&
				!resume_request && step_request && step_ok;
			step_refuse_reg <= (mode_reg == MODE_HOLD) &&
				step_request && !step_ok;
			// Faults stay visible until the next start-up
			wdog_fault_reg  <= wdog_expire ||
				(wdog_fault_reg && !entering_startup);
			cycle_fault_reg <= cycle_expire ||
				(cycle_fault_reg && !entering_startup);
			// Only while stopped; card and address data are not touched
			erase_reg       <= overall_reset &&
				(mode_reg == MODE_STOP);
			first_cycle_reg <= (phase_next == PH_CLEAR_OUT);
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Image and counters are never cleared on stop entry
	assign mode                = mode_reg;
	assign output_lock         = lock_reg;
	assign run_lamp            = lamp_run_reg;
	assign stop_lamp           = lamp_stop_reg;
	assign aout_value          = aout_reg;
	assign exec_enable         = (mode_reg == MODE_RUN) ||
		(mode_reg == MODE_STARTUP);
	assign timers_enable       = (mode_reg == MODE_RUN);
	assign clear_input_image   = (mode_reg == MODE_STARTUP) &&
		(phase_reg == PH_CLEAR_IN);
	assign run_startup_routine = (mode_reg == MODE_STARTUP) &&
		(phase_reg == PH_STARTUP);
	assign clear_output_image  = first_cycle_reg;
	assign read_input_image    = (mode_reg == MODE_RUN) &&
		(phase_reg == PH_READ_IN);
	assign run_cyclic_routine  = (mode_reg == MODE_RUN) &&
		(phase_reg == PH_EXEC);
	assign write_output_image  = (mode_reg == MODE_RUN) &&
		(phase_reg == PH_WRITE_OUT);
	assign step_granted        = step_grant_reg;
	assign step_refused        = step_refuse_reg;
	assign wdog_fault          = wdog_fault_reg;
	assign cycle_fault         = cycle_fault_reg;
	assign erase_user_mem      = erase_reg;

endmodule : plc_mode_ctrl

`default_nettype wire

/* bench/plc_mode_ctrl_properties.sv */
// Port checks for the operating-mode controller.
// Assumes one clock and the synchronous active-high reset.
`default_nettype none

module plc_mode_ctrl_checker
	import mode_ctrl_pkg::*;
(
	input wire logic              sys_clk,             // Clock
	input wire logic              rst,                 // Reset
	input wire logic              run_request,         // Run
	input wire logic              stop_request,        // Stop
	input wire logic              startup_done,        // Start-up end
	input wire logic              startup_error,       // Start-up fail
	input wire logic              bp_reached,          // Breakpoint
	input wire logic [1:0]        bp_count,            // Breakpoints
	input wire logic              bp_active,           // Enabled
	input wire logic              step_request,        // Step
	input wire aout_range_t       aout_range,          // Range
	input wire logic [AOUT_W-1:0] aout_subst,          // Substitute
	input wire op_mode_t          mode,                // Mode
	input wire logic              output_lock,         // Lock
	input wire logic              stop_lamp,           // Stop lamp
	input wire logic [AOUT_W-1:0] aout_value,          // Analog
	input wire logic              exec_enable,         // Execution
	input wire logic              timers_enable,       // Timers
	input wire logic              clear_input_image,   // Clear
	input wire logic              run_startup_routine, // Start-up
	input wire logic              run_cyclic_routine,  // Execute
	input wire logic              step_granted,        // Granted
	input wire logic              step_refused,        // Refused
	input wire logic              cycle_fault          // Overrun
);
	wire logic [AOUT_W-1:0] safe_val;

	assign safe_val = (aout_range == AOUT_SUBST) ? aout_subst :
		(aout_range == AOUT_CUR_4_20) ? AOUT_4MA : AOUT_ZERO;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Mode outputs
	// ----------------------------------------
	property p_stop;
		mode == MODE_STOP |-> output_lock && stop_lamp && !exec_enable;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop mode outputs wrong");
	property p_startup;
		mode == MODE_STARTUP |-> output_lock && !stop_lamp;
	endproperty
	a_startup: assert property (p_startup)
		else $error("start-up outputs wrong");
	property p_run;
		mode == MODE_RUN |-> !output_lock && !stop_lamp;
	endproperty
	a_run: assert property (p_run)
		else $error("run outputs wrong");
	property p_hold;
		mode == MODE_HOLD |-> output_lock && stop_lamp && !exec_enable
			&& !timers_enable;
	endproperty
	a_hold: assert property (p_hold)
		else $error("hold outputs wrong");
	property p_safe;
		output_lock && $past(output_lock) && !$past(rst)
			&& $stable(aout_range) && $stable(aout_subst)
			|-> aout_value == safe_val;
	endproperty
	a_safe: assert property (p_safe)
		else $error("analog safe value wrong");

	// ----------------------------------------
	// Transitions
	// ----------------------------------------
	property p_begin;
		mode == MODE_STOP && run_request && !stop_request
			|=> clear_input_image ##1 run_startup_routine;
	endproperty
	a_begin: assert property (p_begin)
		else $error("start-up sequence wrong");
	property p_to_run;
		mode == MODE_STARTUP && run_startup_routine && startup_done
			&& !startup_error && !stop_request |=> mode == MODE_RUN;
	endproperty
	a_to_run: assert property (p_to_run)
		else $error("no run after start-up");
	property p_halt;
		mode == MODE_RUN && run_cyclic_routine && bp_reached && bp_active
			&& !stop_request |=> mode == MODE_HOLD;
	endproperty
	a_halt: assert property (p_halt)
		else $error("breakpoint did not halt");
	property p_refuse;
		mode == MODE_HOLD && step_request && bp_count > 2'h2 && !stop_request
			|=> step_refused && !step_granted && mode == MODE_HOLD;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("step not refused");
	property p_grant;
		mode == MODE_HOLD && step_request && bp_count <= 2'h2
			&& !stop_request |=> step_granted && !step_refused;
	endproperty
	a_grant: assert property (p_grant)
		else $error("step not granted");
	property p_overrun;
		$rose(cycle_fault) |-> ##[0:1] mode == MODE_STOP;
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun did not stop");
endmodule : plc_mode_ctrl_checker

bind plc_mode_ctrl plc_mode_ctrl_checker plc_mode_ctrl_checker_inst (
	.sys_clk, .rst, .run_request, .stop_request, .startup_done,
	.startup_error, .bp_reached, .bp_count, .bp_active, .step_request,
	.aout_range, .aout_subst, .mode, .output_lock, .stop_lamp,
	.aout_value, .exec_enable, .timers_enable, .clear_input_image,
	.run_startup_routine, .run_cyclic_routine, .step_granted,
	.step_refused, .cycle_fault
);

`default_nettype wire

/* bench/station_model.sv */
// Station and I/O side: ends start-up and cycle phases on request.
// Assumes the controller's phase levels; answers fast, slow or never.
`default_nettype none

module station_model (
	input  wire logic sys_clk,      // Clock
	input  wire logic rst,          // Reset
	input  wire logic slow,         // Long answers
	input  wire logic stall,        // Withhold answers
	input  wire logic startup_lvl,  // Start-up running
	input  wire logic phase_lvl,    // Cycle phase running
	output logic      startup_done, // Start-up finished
	output logic      phase_done,   // Phase finished
	output logic      wdog_kick     // Watchdog retrigger
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_reg;
	logic       done_reg;
	logic       su_reg;
	wire logic  busy;

	assign busy = startup_lvl || phase_lvl;
	always_ff @(posedge sys_clk) begin
		if (rst || !busy || done_reg) begin
			cnt_reg  <= 4'h0;
			done_reg <= 1'b0;
		end else if (!stall) begin
			cnt_reg  <= cnt_reg + 4'h1;
			done_reg <= cnt_reg == (slow ? 4'h6 : 4'h0);
		end
		su_reg <= startup_lvl;
	end
	// Answer goes to whichever routine is running
	assign startup_done = done_reg && su_reg;
	assign phase_done   = done_reg && !su_reg;
	assign wdog_kick    = phase_done;
endmodule : station_model

`default_nettype wire

/* bench/plc_mode_ctrl_tb_top.sv */
// Self-checking bench for the operating-mode controller.
// Assumes the station model and the bound property checker.
`default_nettype none

module plc_mode_ctrl_tb_top
	import mode_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		aout_range_t rng;
		logic [15:0] subst;
		logic [15:0] expv;
	} row_t;
	row_t rows [4] = '{'{AOUT_VOLT, 16'hABCD, 16'h0000},
		'{AOUT_CUR_0_20, 16'hABCD, 16'h0000},
		'{AOUT_CUR_4_20, 16'hABCD, AOUT_4MA},
		'{AOUT_SUBST, 16'h5A5A, 16'h5A5A}};
	logic sys_clk, rst, run_request, stop_request, startup_error;
	logic bp_reached, bp_active, step_request, resume_request;
	logic overall_reset, slow, stall;
	logic startup_done, phase_done, wdog_kick;
	logic [1:0] bp_count;
	logic [TIMER_W-1:0] cycle_limit;
	aout_range_t aout_range;
	logic [AOUT_W-1:0] aout_subst, aout_prog, aout_value;
	op_mode_t mode;
	logic output_lock, run_lamp, stop_lamp, exec_enable, timers_enable;
	logic clear_input_image, clear_output_image, read_input_image;
	logic run_cyclic_routine, write_output_image, run_startup_routine;
	logic step_granted, step_refused, wdog_fault, cycle_fault;
	logic erase_user_mem;
	int failures = 0;
	int checks_done = 0;
	int n;

	plc_mode_ctrl plc_mode_ctrl_inst (.sys_clk, .rst, .run_request,
		.stop_request, .startup_done, .startup_error, .phase_done,
		.bp_reached, .bp_count, .bp_active, .step_request, .resume_request,
		.wdog_kick, .cycle_limit, .overall_reset, .aout_range, .aout_subst,
		.aout_prog, .mode, .output_lock, .run_lamp, .stop_lamp, .aout_value,
		.exec_enable, .timers_enable, .clear_input_image,
		.clear_output_image, .read_input_image, .run_cyclic_routine,
		.write_output_image, .run_startup_routine, .step_granted,
		.step_refused, .wdog_fault, .cycle_fault, .erase_user_mem);
	station_model station_model_inst (.sys_clk, .rst, .slow, .stall,
		.startup_lvl(run_startup_routine), .phase_lvl(read_input_image ||
		run_cyclic_routine || write_output_image), .startup_done,
		.phase_done, .wdog_kick);

	always #25 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		checks_done++;
		if (seen !== expv) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				expv);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : tick
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask : pulse
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 100 && s !== 1'b1; i++) tick(1);
		chk(s, 1'b1);
	endtask : wait_hi
	task automatic end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	initial begin
		#(50 * 60000);
		failures++;
		end_sim();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{sys_clk, run_request, stop_request, startup_error} = '0;
		{bp_reached, bp_active, step_request, resume_request} = '0;
		{overall_reset, slow, stall, bp_count} = '0;
		rst = 1'b1;
		cycle_limit = 27'h64;
		aout_range = AOUT_VOLT;
		aout_subst = 16'h0000;
		aout_prog = 16'h1234;
		tick(4);
		rst = 1'b0;
		chk({mode, output_lock, stop_lamp, run_lamp}, 5'h06);
		foreach (rows[i]) begin
			aout_range = rows[i].rng;
			aout_subst = rows[i].subst;
			tick(2);
			chk(aout_value, rows[i].expv);
		end
		aout_range = AOUT_CUR_4_20;
		slow = 1'b1;
		pulse(run_request);
		chk({mode, stop_lamp, output_lock}, 4'h5);
		chk(clear_input_image, 1'b1);
		tick(1);
		chk(run_startup_routine, 1'b1);
		chk(run_lamp, 1'b1);
		pulse(startup_error);
		chk(mode, MODE_STOP);
		chk({run_lamp, stop_lamp, exec_enable}, 3'h6);
		slow = 1'b0;
		pulse(run_request);
		for (n = 0; n < 200 && mode !== MODE_RUN; n++) tick(1);
		chk({mode, output_lock, stop_lamp}, 4'h8);
		chk(timers_enable, 1'b1);
		chk({clear_output_image, aout_value}, {1'b1, 16'h1234});
		wait_hi(read_input_image);
		wait_hi(run_cyclic_routine);
		chk(read_input_image, 1'b0);
		wait_hi(write_output_image);
		chk(run_cyclic_routine, 1'b0);
		slow = 1'b1;
		bp_active = 1'b1;
		bp_count = 2'h3;
		wait_hi(run_cyclic_routine);
		pulse(bp_reached);
		chk(mode, MODE_HOLD);
		chk({output_lock, stop_lamp, exec_enable}, 3'h6);
		chk(timers_enable, 1'b0);
		tick(3);
		pulse(step_request);
		chk({step_refused, step_granted, mode}, 4'hB);
		bp_count = 2'h2;
		tick(1);
		pulse(step_request);
		chk({step_granted, mode}, 3'h6);
		wait_hi(run_cyclic_routine);
		pulse(bp_reached);
		chk(mode, MODE_HOLD);
		pulse(resume_request);
		chk(mode, MODE_RUN);
		bp_active = 1'b0;
		tick(3);
		pulse(stop_request);
		chk({mode, output_lock}, 3'h1);
		chk(aout_value, AOUT_4MA);
		pulse(overall_reset);
		chk(erase_user_mem, 1'b1);
		pulse(run_request);
		for (n = 0; n < 200 && mode !== MODE_RUN; n++) tick(1);
		stall = 1'b1;
		for (n = 0; n < 30000 && cycle_fault !== 1'b1; n++) tick(1);
		chk(n >= 19000 && n <= 20100, 1'b1);
		tick(1);
		chk(mode, MODE_STOP);
		chk({cycle_fault, wdog_fault}, 2'h2);
		stall = 1'b0;
		end_sim();
	end
endmodule : plc_mode_ctrl_tb_top

`default_nettype wire
